// *** include/tss_pkg.sv ***
/*
  shared types and constants of the transfer sequence store.
  assumes one 10 MHz clock and a synchronous active-high reset.
*/
`default_nettype none
package tss_pkg;
  // ----------------------------------------
  // sizes
  // ----------------------------------------
  localparam int         NUM_LISTS  = 4;
  localparam int         LIST_W     = 2;
  localparam int         IDX_W      = 7;
  localparam int         MEM_AW     = LIST_W + IDX_W;
  localparam int         FIFO_DEPTH = 8;
  localparam logic [6:0] MAX_ELEMS  = 7'h64;
  localparam logic [2:0] FIELD_CNT  = 3'h4;
  localparam logic [1:0] DEFAULT_LIST = 2'h0;
  localparam logic [2:0] LAST_LIST_NUM = 3'h4;
  // ----------------------------------------
  // operation codes
  // ----------------------------------------
  localparam logic [15:0] OP_TERMINATE = 16'h0001;
  localparam logic [3:0]  GRP_LB_TX    = 4'h1;
  localparam logic [3:0]  GRP_LB_RX    = 4'h2;
  localparam logic [3:0]  GRP_VX_TX    = 4'h3;
  localparam logic [3:0]  GRP_VX_RX    = 4'h4;
  localparam logic [3:0]  GRP_LB_MON   = 4'h5;
  localparam logic [3:0]  DEC_ROUND    = 4'h5;
  localparam logic [3:0]  DEC_MAX      = 4'h9;
  // ----------------------------------------
  // types
  // ----------------------------------------
  typedef enum logic [2:0] {
    TK_DIGIT  = 3'h0,
    TK_FRAC   = 3'h1,
    TK_MINUS  = 3'h2,
    TK_RADIX  = 3'h3,
    TK_NEXT   = 3'h4,
    TK_APPEND = 3'h5,
    TK_DELETE = 3'h6
  } tss_tok_kind_t;
  typedef enum logic [1:0] {
    RX_DEC = 2'h0,
    RX_HEX = 2'h1,
    RX_OCT = 2'h2,
    RX_BIN = 2'h3
  } tss_radix_t;
  typedef enum logic [2:0] {
    ERR_NONE   = 3'h0,
    ERR_NEG    = 3'h1,
    ERR_DIGIT  = 3'h2,
    ERR_FIELDS = 3'h3,
    ERR_FULL   = 3'h4,
    ERR_BUSY   = 3'h5,
    ERR_EMPTY  = 3'h6,
    ERR_NOPROG = 3'h7
  } tss_err_t;
  typedef enum logic [1:0] {
    ST_IDLE  = 2'h0,
    ST_FETCH = 2'h1,
    ST_ISSUE = 2'h2
  } tss_state_t;
  typedef struct packed {
    tss_tok_kind_t kind;
    logic [3:0]    data;
  } tss_tok_t;
  typedef struct packed {
    logic              dir_rx;
    logic [LIST_W-1:0] list;
    logic [31:0]       total;
  } tss_start_t;
  typedef struct packed {
    logic [15:0] op;
    logic [31:0] count;
    logic [31:0] addr;
    logic [31:0] aux;
  } tss_elem_t;
  typedef struct packed {
    logic        dir_rx;
    logic [15:0] op;
    logic [31:0] bytes;
    logic [31:0] addr;
    logic [31:0] aux;
  } tss_desc_t;
endpackage : tss_pkg
`default_nettype wire

// *** logic/tss_list_mem.sv ***
/*
  element store for all lists, one write and one registered read port.
  assumes the caller keeps addresses inside the lists it has filled.
*/
`default_nettype none
module tss_list_mem
  import tss_pkg::*;
(
  input  wire logic              clk,
  input  wire logic              rst,
  input  wire logic              we,
  input  wire logic [MEM_AW-1:0] waddr,
  input  wire tss_elem_t         wdata,
  input  wire logic [MEM_AW-1:0] raddr,
  output tss_elem_t              rdata
);
  // ----------------------------------------
  // storage
  // ----------------------------------------
  tss_elem_t mem [2**MEM_AW];
  tss_elem_t rdata_ff;

  always_ff @(posedge clk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
    if (rst) begin
      rdata_ff <= '0;
    end else begin
      rdata_ff <= mem[raddr];
    end
  end

  assign rdata = rdata_ff;
endmodule : tss_list_mem
`default_nettype wire

// *** logic/tss_fifo.sv ***
/*
  small synchronous fifo with valid/ready on both sides.
  assumes DEPTH is a power of two.
*/
`default_nettype none
module tss_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  input  wire logic             clk,
  input  wire logic             rst,
  input  wire logic             in_valid,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  in_ready,
  output logic                  out_valid,
  output logic [WIDTH-1:0]      out_data,
  input  wire logic             out_ready
);
  localparam int AW = $clog2(DEPTH);
  localparam logic [AW:0] FULL_CNT = (AW+1)'(DEPTH);

  logic [WIDTH-1:0] buf_ff [DEPTH];
  logic [WIDTH-1:0] nxt_buf [DEPTH];
  logic [AW-1:0]    wp_ff, nxt_wp, rp_ff, nxt_rp;
  logic [AW:0]      cnt_ff, nxt_cnt;
  logic             push, pop;

  assign in_ready  = cnt_ff != FULL_CNT;
  assign out_valid = cnt_ff != '0;
  assign out_data  = buf_ff[rp_ff];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  always_comb begin
    nxt_buf = buf_ff;
    nxt_wp  = wp_ff;
    nxt_rp  = rp_ff;
    nxt_cnt = cnt_ff;
    if (push) begin
      nxt_buf[wp_ff] = in_data;
      nxt_wp         = wp_ff + 1'b1;
    end
    if (pop) begin
      nxt_rp = rp_ff + 1'b1;
    end
    if (push && !pop) begin
      nxt_cnt = cnt_ff + 1'b1;
    end else if (pop && !push) begin
      nxt_cnt = cnt_ff - 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      buf_ff <= '{default: '0};
      wp_ff  <= '0;
      rp_ff  <= '0;
      cnt_ff <= '0;
    end else begin
      buf_ff <= nxt_buf;
      wp_ff  <= nxt_wp;
      rp_ff  <= nxt_rp;
      cnt_ff <= nxt_cnt;
    end
  end
endmodule : tss_fifo
`default_nettype wire

// *** logic/tss_seq_store.sv ***
/*
  transfer sequence store: builds element lists from a token stream and
  runs one list at a time, emitting transfer descriptors through a fifo.
  assumes a parser upstream that splits host text into tokens, and a
  data mover downstream that drains descriptors.
*/
`default_nettype none
module tss_seq_store
  import tss_pkg::*;
(
  input  wire logic         clk,
  input  wire logic         rst,
  input  wire logic         tok_valid,
  input  wire tss_tok_t     tok,
  input  wire logic         start_run_short,
  input  wire tss_start_t   start_cmd,
  output logic              desc_valid,
  output tss_desc_t         desc,
  input  wire logic         desc_ready,
  output logic              busy,
  output logic [LIST_W-1:0] active_list,
  output logic              done,
  output logic              err,
  output tss_err_t          err_code
);
  // ----------------------------------------
  // field entry state
  // ----------------------------------------
  logic [31:0]      acc_ff, nxt_acc;
  tss_radix_t       radix_ff, nxt_radix;
  logic             neg_ff, nxt_neg, frac_ff, nxt_frac, rnd_ff, nxt_rnd;
  logic             bad_ff, nxt_bad;
  logic [2:0]       fidx_ff, nxt_fidx;
  logic [31:0]      fld_ff [4], nxt_fld [4];
  logic [IDX_W-1:0] size_ff [NUM_LISTS], nxt_size [NUM_LISTS];
  logic [4:0]       base;
  logic [1:0]       tgt;
  logic             tgt_bad, mem_we, ent_err;
  tss_err_t         ent_code;
  tss_elem_t        elem_w, rd;
  // ----------------------------------------
  // run state
  // ----------------------------------------
  tss_state_t        state_ff, nxt_state;
  logic [LIST_W-1:0] list_ff, nxt_list;
  logic [IDX_W-1:0]  idx_ff, nxt_idx;
  logic [31:0]       rem_ff, nxt_rem, ebytes, clip;
  logic              dir_ff, nxt_dir, moved_ff, nxt_moved;
  logic              blocks, xfer, push, fifo_rdy, wrap, run_err, done_now;
  tss_err_t          run_code, code_ff;
  logic              err_ff, done_ff;
  tss_desc_t         desc_in;
  assign base    = (radix_ff == RX_HEX) ? 5'h10 : (radix_ff == RX_OCT) ? 5'h08
                 : (radix_ff == RX_BIN) ? 5'h02 : 5'h0a;
  assign tgt     = (tok.data[2:0] == 3'h0) ? DEFAULT_LIST : 2'(tok.data[2:0] - 3'h1);
  assign tgt_bad = tok.data > {1'b0, LAST_LIST_NUM};
  assign elem_w  = '{op: fld_ff[0][15:0], count: fld_ff[1], addr: fld_ff[2], aux: fld_ff[3]};
  always_comb begin
    nxt_acc   = acc_ff;
    nxt_radix = radix_ff;
    nxt_neg   = neg_ff;
    nxt_frac  = frac_ff;
    nxt_rnd   = rnd_ff;
    nxt_bad   = bad_ff;
    nxt_fidx  = fidx_ff;
    nxt_fld   = fld_ff;
    nxt_size  = size_ff;
    mem_we    = 1'b0;
    ent_err   = 1'b0;
    ent_code  = ERR_NONE;
    if (tok_valid) begin
      if (tok.kind == TK_NEXT || tok.kind == TK_APPEND) begin
        nxt_acc   = '0;
        nxt_radix = RX_DEC;
        nxt_neg   = 1'b0;
        nxt_frac  = 1'b0;
        nxt_rnd   = 1'b0;
      end
      case (tok.kind)
        TK_DIGIT: begin
          if ({1'b0, tok.data} >= base) begin
            ent_err  = 1'b1;
            ent_code = ERR_DIGIT;
            nxt_bad  = 1'b1;
          end else begin
            nxt_acc = acc_ff * {27'h0, base} + {28'h0, tok.data};
          end
        end
        TK_FRAC: begin
          // only the first fraction digit decides nearest rounding
          if (radix_ff != RX_DEC || tok.data > DEC_MAX) begin
            ent_err  = 1'b1;
            ent_code = ERR_DIGIT;
            nxt_bad  = 1'b1;
          end else if (!frac_ff) begin
            nxt_frac = 1'b1;
            nxt_rnd  = tok.data >= DEC_ROUND;
          end
        end
        TK_MINUS: nxt_neg = 1'b1;
        TK_RADIX: nxt_radix = tss_radix_t'(tok.data[1:0]);
        TK_NEXT: begin
          if (neg_ff) begin
            ent_err  = 1'b1;
            ent_code = ERR_NEG;
            nxt_bad  = 1'b1;
          end else if (fidx_ff == FIELD_CNT) begin
            ent_err  = 1'b1;
            ent_code = ERR_FIELDS;
            nxt_bad  = 1'b1;
          end else begin
            nxt_fld[fidx_ff[1:0]] = acc_ff + {31'h0, rnd_ff};
          end
          if (fidx_ff != FIELD_CNT) begin
            nxt_fidx = fidx_ff + 3'h1;
          end
        end
        TK_APPEND: begin
          nxt_fidx  = '0;
          nxt_bad   = 1'b0;
          if (bad_ff || fidx_ff != FIELD_CNT || tgt_bad) begin
            ent_err  = 1'b1;
            ent_code = ERR_FIELDS;
          end else if (size_ff[tgt] == MAX_ELEMS) begin
            ent_err  = 1'b1;
            ent_code = ERR_FULL;
          end else begin
            mem_we        = 1'b1;
            nxt_size[tgt] = size_ff[tgt] + 7'h1;
          end
        end
        TK_DELETE: begin
          if (tgt_bad) begin
            ent_err  = 1'b1;
            ent_code = ERR_FIELDS;
          end else if (busy && tgt == list_ff) begin
            ent_err  = 1'b1;
            ent_code = ERR_BUSY;
          end else begin
            nxt_size[tgt] = '0;
          end
        end
        default: ;
      endcase
    end
  end
  tss_list_mem u_mem (
    .clk   (clk),
    .rst   (rst),
    .we    (mem_we),
    .waddr ({tgt, size_ff[tgt]}),
    .wdata (elem_w),
    .raddr ({list_ff, idx_ff}),
    .rdata (rd)
  );
  // ----------------------------------------
  // run engine
  // ----------------------------------------
  assign blocks = rd.op[15:12] == GRP_LB_TX || rd.op[15:12] == GRP_LB_RX
               || rd.op[15:12] == GRP_LB_MON;
  assign xfer   = rd.op[15:12] >= GRP_LB_TX && rd.op[15:12] <= GRP_LB_MON;
  // local-bus count is blocks; aux low half holds bytes per block
  assign ebytes = blocks ? rd.count * {16'h0, rd.aux[15:0]} : rd.count;
  assign clip   = !xfer ? 32'h0 : (ebytes > rem_ff) ? rem_ff : ebytes;
  assign wrap   = idx_ff + 7'h1 == size_ff[list_ff];
  // address is carried as an unbiased offset into the selected space
  assign desc_in = '{dir_rx: dir_ff, op: rd.op, bytes: clip, addr: rd.addr, aux: rd.aux};
  always_comb begin
    nxt_state = state_ff;
    nxt_list  = list_ff;
    nxt_idx   = idx_ff;
    nxt_rem   = rem_ff;
    nxt_dir   = dir_ff;
    nxt_moved = moved_ff;
    run_err   = 1'b0;
    run_code  = ERR_NONE;
    done_now  = 1'b0;
    push      = 1'b0;
    case (state_ff)
      ST_IDLE: begin
        if (start_run_short) begin
          if (size_ff[start_cmd.list] == '0) begin
            run_err  = 1'b1;
            run_code = ERR_EMPTY;
          end else if (start_cmd.total == '0) begin
            done_now = 1'b1;
          end else begin
            nxt_list  = start_cmd.list;
            nxt_idx   = '0;
            nxt_rem   = start_cmd.total;
            nxt_dir   = start_cmd.dir_rx;
            nxt_moved = 1'b0;
            nxt_state = ST_FETCH;
          end
        end
      end
      ST_FETCH: nxt_state = ST_ISSUE;
      ST_ISSUE: begin
        if (rd.op == OP_TERMINATE) begin
          done_now  = 1'b1;
          nxt_state = ST_IDLE;
        end else if (fifo_rdy) begin
          push      = 1'b1;
          nxt_rem   = rem_ff - clip;
          nxt_moved = moved_ff || clip != '0;
          nxt_state = ST_FETCH;
          nxt_idx   = idx_ff + 7'h1;
          if (rem_ff == clip) begin
            done_now  = 1'b1;
            nxt_state = ST_IDLE;
          end else if (wrap) begin
            // a pass that moves nothing would loop forever
            if (!moved_ff && clip == '0) begin
              run_err   = 1'b1;
              run_code  = ERR_NOPROG;
              nxt_state = ST_IDLE;
            end else begin
              nxt_idx   = '0;
              nxt_moved = 1'b0;
            end
          end
        end
      end
      default: nxt_state = ST_IDLE;
    endcase
    if (start_run_short && state_ff != ST_IDLE) begin
      run_err  = 1'b1;
      run_code = ERR_BUSY;
    end
  end
  tss_fifo #(
    .WIDTH ($bits(tss_desc_t)),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk       (clk),
    .rst       (rst),
    .in_valid  (push),
    .in_data   (desc_in),
    .in_ready  (fifo_rdy),
    .out_valid (desc_valid),
    .out_data  (desc),
    .out_ready (desc_ready)
  );
  always_ff @(posedge clk) begin
    if (rst) begin
      acc_ff   <= '0;
      radix_ff <= RX_DEC;
      neg_ff   <= 1'b0;
      frac_ff  <= 1'b0;
      rnd_ff   <= 1'b0;
      bad_ff   <= 1'b0;
      fidx_ff  <= '0;
      fld_ff   <= '{default: '0};
      size_ff  <= '{default: '0};
      state_ff <= ST_IDLE;
      list_ff  <= '0;
      idx_ff   <= '0;
      rem_ff   <= '0;
      dir_ff   <= 1'b0;
      moved_ff <= 1'b0;
      err_ff   <= 1'b0;
      code_ff  <= ERR_NONE;
      done_ff  <= 1'b0;
    end else begin
      acc_ff   <= nxt_acc;
      radix_ff <= nxt_radix;
      neg_ff   <= nxt_neg;
      frac_ff  <= nxt_frac;
      rnd_ff   <= nxt_rnd;
      bad_ff   <= nxt_bad;
      fidx_ff  <= nxt_fidx;
      fld_ff   <= nxt_fld;
      size_ff  <= nxt_size;
      state_ff <= nxt_state;
      list_ff  <= nxt_list;
      idx_ff   <= nxt_idx;
      rem_ff   <= nxt_rem;
      dir_ff   <= nxt_dir;
      moved_ff <= nxt_moved;
      err_ff   <= run_err || ent_err;
      code_ff  <= run_err ? run_code : ent_code;
      done_ff  <= done_now;
    end
  end
  assign busy        = state_ff != ST_IDLE;
  assign active_list = list_ff;
  assign done        = done_ff;
  assign err         = err_ff;
  assign err_code    = code_ff;
  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  AST_BUSY_REFUSE: assert property (busy && start_run_short |=> err && err_code == ERR_BUSY)
    else $error("start during a run not refused");
  AST_ONE_RUN: assert property (busy && start_run_short |=> $stable(active_list))
    else $error("running list changed by a second start");
  AST_CAP: assert property (size_ff[0] <= MAX_ELEMS && size_ff[3] <= MAX_ELEMS)
    else $error("list grew past its limit");
  AST_GROW: assert property (mem_we && tgt == 2'h0 |=> size_ff[0] == $past(size_ff[0]) + 7'h1)
    else $error("append did not add one element");
  AST_DEFLIST: assert property (mem_we && tok.data == 4'h0 |-> tgt == DEFAULT_LIST)
    else $error("unnamed append missed the first list");
  AST_FIELDS: assert property (tok_valid && tok.kind == TK_APPEND && fidx_ff != FIELD_CNT
                               |-> !mem_we ##1 err)
    else $error("append with missing fields accepted");
  AST_START: assert property (!busy && start_run_short && size_ff[start_cmd.list] != '0
                              && start_cmd.total != '0 |=> busy ##1 busy)
    else $error("valid start did not begin a run");
  AST_REPEAT: assert property (state_ff == ST_ISSUE && push && wrap && !done_now && !run_err
                               |=> state_ff == ST_FETCH && idx_ff == '0 ##1 state_ff == ST_ISSUE)
    else $error("list not rerun from its start");
  AST_NEG: assert property (tok_valid && tok.kind == TK_NEXT && neg_ff && !run_err
                            |=> err && err_code == ERR_NEG)
    else $error("negative field not reported");
  AST_DRAIN: assert property (desc_valid && !desc_ready |=> desc_valid && $stable(desc))
    else $error("descriptor dropped under back-pressure");
  COV_WRAP: cover property (push && wrap && !done_now && !run_err);
  COV_DONE: cover property (busy ##1 done);
  COV_FULL: cover property (err && err_code == ERR_FULL);
  COV_STALL: cover property (state_ff == ST_ISSUE && !fifo_rdy);
endmodule : tss_seq_store
`default_nettype wire

// *** bench/tss_desc_sink.sv ***
/*
  descriptor sink standing in for the data mover behind the store.
  assumes the bench drives slow and hold by non-blocking assignment.
*/
`default_nettype none
module tss_desc_sink
  import tss_pkg::*;
(
  input  wire logic      clk,
  input  wire logic      rst,
  input  wire logic      desc_valid,
  input  wire tss_desc_t desc,
  input  wire logic      slow,
  input  wire logic      hold,
  output var  logic      desc_ready
);
  timeunit 1ns;
  timeprecision 1ns;
  tss_desc_t got[$];
  // slow halves the take rate; hold stalls it so the fifo fills
  always @(posedge clk) begin
    if (rst) begin
      desc_ready <= 1'b0;
    end else begin
      if (desc_valid && desc_ready) begin
        got.push_back(desc);
      end
      desc_ready <= !hold && (!slow || !desc_ready);
    end
  end
endmodule : tss_desc_sink
`default_nettype wire

// *** bench/transfer_sequence_store_test.sv ***
/*
  self-checking bench of the transfer sequence store.
  assumes the package, design files and descriptor sink come first.
*/
`default_nettype none
module transfer_sequence_store_test
  import tss_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic              clk = 1'b0;
  logic              rst = 1'b1;
  logic              tok_valid = 1'b0;
  tss_tok_t          tok = '0;
  logic              start_run_short = 1'b0;
  tss_start_t        start_cmd = '0;
  logic              slow = 1'b0;
  logic              hold = 1'b0;
  logic              desc_valid;
  logic              desc_ready;
  logic              busy;
  logic              done;
  logic              err;
  tss_desc_t         desc;
  logic [LIST_W-1:0] active_list;
  tss_err_t          err_code;
  int                bad_count = 0;
  int                num_checks = 0;

  always #50 clk = ~clk;

  tss_seq_store tss_seq_store_i (.clk(clk), .rst(rst), .tok_valid(tok_valid), .tok(tok),
    .start_run_short(start_run_short), .start_cmd(start_cmd), .desc_valid(desc_valid),
    .desc(desc), .desc_ready(desc_ready), .busy(busy), .active_list(active_list),
    .done(done), .err(err), .err_code(err_code));
  tss_desc_sink tss_desc_sink_i (.clk(clk), .rst(rst), .desc_valid(desc_valid),
    .desc(desc), .slow(slow), .hold(hold), .desc_ready(desc_ready));

  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task automatic chk(string name, logic [31:0] seen, logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk

  task automatic tk(tss_tok_kind_t k, logic [3:0] d);
    @(posedge clk);
    tok_valid <= 1'b1;
    tok <= '{kind: k, data: d};
  endtask : tk

  task automatic tk_end();
    @(posedge clk);
    tok_valid <= 1'b0;
  endtask : tk_end

  task automatic put_hex(logic [31:0] v);
    tk(TK_RADIX, 4'h1);
    for (int i = 7; i >= 0; i--) begin
      tk(TK_DIGIT, v[i*4 +: 4]);
    end
    tk(TK_NEXT, 4'h0);
  endtask : put_hex

  // aux always zero here, unused by these operations
  task automatic add_elem(logic [3:0] num, logic [15:0] op, logic [31:0] cnt, logic [31:0] adr);
    put_hex({16'h0000, op});
    put_hex(cnt);
    put_hex(adr);
    put_hex(32'h0);
    tk(TK_APPEND, num);
  endtask : add_elem

  // err is a one-cycle pulse, so sample every cycle of the window
  task automatic exp_err(tss_err_t code);
    logic     seen_err;
    tss_err_t seen_code;
    seen_err = 1'b0;
    seen_code = ERR_NONE;
    repeat (4) begin
      #1;
      if (err === 1'b1) begin
        seen_err = 1'b1;
        seen_code = err_code;
      end
      @(posedge clk);
    end
    chk("err", {31'h0, seen_err}, 32'h1);
    chk("err_code", {29'h0, seen_code}, {29'h0, code});
  endtask : exp_err

  task automatic run(logic rx, logic [1:0] lst, logic [31:0] total);
    tss_desc_sink_i.got.delete();
    @(posedge clk);
    start_run_short <= 1'b1;
    start_cmd <= '{dir_rx: rx, list: lst, total: total};
    @(posedge clk);
    start_run_short <= 1'b0;
  endtask : run

  task automatic wait_done(int lim);
    int n;
    n = 0;
    #1;
    while (done !== 1'b1 && n < lim) begin
      @(posedge clk);
      #1;
      n++;
    end
    chk("done", {31'h0, done}, 32'h1);
    repeat (20) @(posedge clk);
  endtask : wait_done

  task automatic exp_desc(int i, logic [15:0] op, logic [31:0] nb, logic [31:0] adr, logic rx);
    tss_desc_t d;
    d = tss_desc_sink_i.got[i];
    chk("desc_op", {16'h0, d.op}, {16'h0, op});
    chk("desc_bytes", d.bytes, nb);
    chk("desc_addr", d.addr, adr);
    chk("desc_dir", {31'h0, d.dir_rx}, {31'h0, rx});
  endtask : exp_desc

  task automatic final_report();
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : final_report

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_rerun();
    add_elem(4'h2, 16'h3012, 32'h8, 32'h40);
    tk_end();
    slow <= 1'b1;
    run(1'b0, 2'h1, 32'd20);
    wait_done(200);
    chk("active_list", {30'h0, active_list}, 32'h1);
    chk("count", tss_desc_sink_i.got.size(), 32'h3);
    exp_desc(0, 16'h3012, 32'd8, 32'h40, 1'b0);
    exp_desc(1, 16'h3012, 32'd8, 32'h40, 1'b0);
    exp_desc(2, 16'h3012, 32'd4, 32'h40, 1'b0);
    slow <= 1'b0;
    $display("test rerun finished");
  endtask : t_rerun

  task automatic t_radix();
    put_hex(32'h1000);
    tk(TK_DIGIT, 4'h4);
    tk(TK_FRAC, 4'h5);
    tk(TK_NEXT, 4'h0);
    tk(TK_RADIX, 4'h2);
    tk(TK_DIGIT, 4'h1);
    tk(TK_DIGIT, 4'h7);
    tk(TK_NEXT, 4'h0);
    tk(TK_RADIX, 4'h3);
    tk(TK_DIGIT, 4'h1);
    tk(TK_DIGIT, 4'h0);
    tk(TK_DIGIT, 4'h1);
    tk(TK_NEXT, 4'h0);
    tk(TK_APPEND, 4'h0);
    tk_end();
    run(1'b0, 2'h0, 32'd25);
    wait_done(200);
    chk("count", tss_desc_sink_i.got.size(), 32'h1);
    exp_desc(0, 16'h1000, 32'd25, 32'd15, 1'b0);
    chk("desc_aux", tss_desc_sink_i.got[0].aux, 32'd5);
    $display("test radix finished");
  endtask : t_radix

  task automatic t_ctrl();
    // receive list uses only the backplane bus, no transmit ops
    add_elem(4'h3, 16'h0000, 32'h0, 32'h0);
    add_elem(4'h3, 16'h4012, 32'h3, 32'h0);
    tk_end();
    run(1'b1, 2'h2, 32'd6);
    wait_done(200);
    chk("count", tss_desc_sink_i.got.size(), 32'h4);
    for (int i = 0; i < 4; i++) begin
      exp_desc(i, (i % 2) ? 16'h4012 : 16'h0000, (i % 2) ? 32'd3 : 32'd0, 32'h0, 1'b1);
    end
    $display("test control finished");
  endtask : t_ctrl

  task automatic t_fill();
    add_elem(4'h4, 16'h3012, 32'h1, 32'h0);
    tk_end();
    hold <= 1'b1;
    run(1'b0, 2'h3, 32'd10);
    repeat (40) @(posedge clk);
    #1;
    chk("desc_valid", {31'h0, desc_valid}, 32'h1);
    chk("count", tss_desc_sink_i.got.size(), 32'h0);
    run(1'b0, 2'h3, 32'd10);
    exp_err(ERR_BUSY);
    chk("busy", {31'h0, busy}, 32'h1);
    tk(TK_DELETE, 4'h4);
    tk_end();
    exp_err(ERR_BUSY);
    hold <= 1'b0;
    wait_done(300);
    chk("count", tss_desc_sink_i.got.size(), 32'd10);
    for (int i = 0; i < 10; i++) begin
      exp_desc(i, 16'h3012, 32'd1, 32'h0, 1'b0);
    end
    $display("test fill finished");
  endtask : t_fill

  task automatic t_errors();
    tk(TK_MINUS, 4'h0);
    tk(TK_DIGIT, 4'h1);
    tk(TK_NEXT, 4'h0);
    tk_end();
    exp_err(ERR_NEG);
    tk(TK_APPEND, 4'h1);
    tk_end();
    exp_err(ERR_FIELDS);
    tk(TK_RADIX, 4'h2);
    tk(TK_DIGIT, 4'h8);
    tk_end();
    exp_err(ERR_DIGIT);
    // a poisoned field lingers until an append clears the entry
    tk(TK_APPEND, 4'h1);
    tk_end();
    exp_err(ERR_FIELDS);
    tk(TK_DELETE, 4'h2);
    tk_end();
    run(1'b0, 2'h1, 32'd8);
    exp_err(ERR_EMPTY);
    add_elem(4'h2, 16'h0000, 32'h0, 32'h0);
    tk_end();
    run(1'b0, 2'h1, 32'd8);
    exp_err(ERR_NOPROG);
    add_elem(4'h2, 16'h0001, 32'h0, 32'h0);
    tk_end();
    run(1'b0, 2'h1, 32'd8);
    wait_done(50);
    $display("test errors finished");
  endtask : t_errors

  task automatic t_full();
    tk(TK_DELETE, 4'h1);
    for (int i = 0; i < 100; i++) begin
      add_elem(4'h1, 16'h3012, 32'h1, i);
    end
    add_elem(4'h1, 16'h3012, 32'h1, 32'h99);
    tk_end();
    exp_err(ERR_FULL);
    run(1'b0, 2'h0, 32'd101);
    wait_done(1000);
    chk("count", tss_desc_sink_i.got.size(), 32'd101);
    chk("addr_last", tss_desc_sink_i.got[99].addr, 32'd99);
    chk("addr_wrap", tss_desc_sink_i.got[100].addr, 32'd0);
    $display("test full finished");
  endtask : t_full

  // ----------------------------------------
  // sequence and watchdog
  // ----------------------------------------
  initial begin
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    #1;
    chk("busy", {31'h0, busy}, 32'h0);
    chk("desc_valid", {31'h0, desc_valid}, 32'h0);
    t_rerun();
    t_radix();
    t_ctrl();
    t_fill();
    t_errors();
    t_full();
    final_report();
  end

  // about four times the expected run length
  initial begin
    #2000000;
    bad_count++;
    final_report();
  end
endmodule : transfer_sequence_store_test
`default_nettype wire
